// ===== hw/pbsp_pkg.sv
// constants and carrier types for the pipelined burst sram port
// assumes one 50 MHz clock and a 36-bit word split into four 9-bit lanes
package pbsp_pkg;
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 9;
    localparam int DATA_W = 32;
    localparam int MEM_DEPTH = 262144;
    localparam int FIFO_DEPTH = 8;
    localparam int BURST_W = 2;
    localparam int CLK_PERIOD_NS = 20;
    // sleep entry and exit time, in clock periods
    localparam int SLEEP_TIME_TCYC = 2;
    localparam int SLEEP_CYCLES = SLEEP_TIME_TCYC * CLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [LANE_W-1:0] LANE_RST = 9'h000;
    localparam logic [LANES-1:0] LANES_OFF = 4'hf;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
    localparam logic [SLEEP_CYCLES-1:0] SLEEP_SYNC_RST = '0;

    typedef enum logic [1:0] {OP_DESELECT, OP_READ, OP_WRITE} pbsp_op_type;
    typedef logic [LANES-1:0][LANE_W-1:0] pbsp_lanes_type;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_en;
        pbsp_lanes_type data;
    } pbsp_wr_entry_type;
endpackage

// ===== hw/pbsp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a power-of-two depth and one clock
`timescale 1ns/1ns
module pbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk, // clock
    input wire logic resetn, // async reset, active low
    input wire logic in_valid, // entry offered
    output logic in_ready, // room for an entry
    input wire logic [WIDTH-1:0] in_data, // entry to store
    output logic out_valid, // head entry present
    input wire logic out_ready, // drain side takes head
    output logic [WIDTH-1:0] out_data // head entry
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W:0] wr_q;
    logic [PTR_W:0] rd_q;
    logic full;
    logic empty;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[PTR_W] != rd_q[PTR_W]) && (wr_q[PTR_W-1:0] == rd_q[PTR_W-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = store[rd_q[PTR_W-1:0]];

    always_ff @(posedge ref_clk) begin
        if (in_valid && !full) begin
            store[wr_q[PTR_W-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
        end else if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= '0;
        end else if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// ===== hw/pbsp_port.sv
// synchronous host port of a pipelined burst sram with no turnaround cycles
// assumes the controller is logic on ref_clk; sleep_request may be asynchronous
// Operation
// - qualify high: edge ignored, state held
// - load, all selects, strobe high starts read
// - read data out after next edge
// - output drive enable low needed to drive
// - new command accepted right after read
// - deselect tri-states after following edge
// - four-step counter on two low bits
// - strap picks linear or interleaved order
// - interleaved: start xor step count
// - linear: start plus step, modulo four
// - advance ignores selects and write strobe
// - access type fixed at burst load
// - load, all selects, strobe low starts write
// - outputs float the edge after write
// - write data captured second edge after
// - only selected lanes with parity stored
// - drive enable asynchronous, masked on writes
// - continuation ignores selects, lanes each cycle
// - sleep high: low power, data kept
// - two cycles in, two out; pending lost
`timescale 1ns/1ns
module pbsp_port (
    input wire logic ref_clk, // clock
    input wire logic resetn, // power-up reset, active low
    input wire logic clock_qualify_n, // high ignores the edge
    input wire logic chip_select_one_n, // select, active low
    input wire logic chip_select_two, // select, active high
    input wire logic chip_select_three_n, // select, active low
    input wire logic advance_or_load, // high advance, low load
    input wire logic write_strobe_n, // low write, high read
    input wire logic [pbsp_pkg::LANES-1:0] byte_lane_write_n, // lane write selects, active low
    input wire logic [pbsp_pkg::ADDR_W-1:0] address, // word address
    input wire logic burst_order_interleaved, // strap: high interleaved
    input wire logic output_drive_enable_n, // async output enable, active low
    input wire logic sleep_request, // async sleep, active high
    input wire logic [pbsp_pkg::DATA_W-1:0] dq_in, // data lines in
    input wire logic [pbsp_pkg::LANES-1:0] parity_lines_in, // parity lines in
    output wire [pbsp_pkg::DATA_W-1:0] dq_out, // data lines out
    output wire [pbsp_pkg::LANES-1:0] parity_lines_out, // parity lines out
    output logic dq_oe, // drives data and parity lines
    output logic write_buffer_ready // write buffer has room
);
    import pbsp_pkg::*;

    logic go;
    logic asleep;
    logic sel;
    logic load;
    logic adv;
    logic [SLEEP_CYCLES-1:0] sleep_sync_q;
    pbsp_op_type op_q;
    logic [ADDR_W-1:0] base_q;
    logic [BURST_W-1:0] step_q;
    logic [BURST_W-1:0] cur_low;
    logic [ADDR_W-1:0] cur_addr;
    logic [LANES-1:0] bw_q;
    logic drive_q;
    logic wr2_valid_q;
    logic [ADDR_W-1:0] wr2_addr_q;
    logic [LANES-1:0] wr2_en_q;
    wire pbsp_lanes_type push_lanes;
    pbsp_wr_entry_type push_entry;
    pbsp_wr_entry_type head;
    logic push_valid;
    logic head_valid;
    logic pop_ready;
    logic head_hit;

    assign go = !clock_qualify_n;
    assign asleep = sleep_sync_q[SLEEP_CYCLES-1];
    assign sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    assign load = go && !asleep && !advance_or_load;
    assign adv = go && !asleep && advance_or_load;

    // sleep passes a short synchroniser; its depth is the entry and exit time
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sleep_sync_q <= SLEEP_SYNC_RST;
        end else begin
            sleep_sync_q <= {sleep_sync_q[SLEEP_CYCLES-2:0], sleep_request};
        end
    end

    // command type; continuation keeps the type latched at load
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            op_q <= OP_DESELECT;
        end else if (asleep) begin
            op_q <= OP_DESELECT;
        end else if (load) begin
            if (!sel) begin
                op_q <= OP_DESELECT;
            end else if (write_strobe_n) begin
                op_q <= OP_READ;
            end else begin
                op_q <= OP_WRITE;
            end
        end
    end

    // address register and burst step counter
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            base_q <= ADDR_RST;
            step_q <= BURST_START;
        end else if (load && sel) begin
            base_q <= address;
            step_q <= BURST_START;
        end else if (adv && op_q != OP_DESELECT) begin
            step_q <= step_q + BURST_STEP;
        end
    end

    // lane selects sampled at every access edge, continuation included
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bw_q <= LANES_OFF;
        end else if ((load && sel) || (adv && op_q != OP_DESELECT)) begin
            bw_q <= byte_lane_write_n;
        end
    end

    always_comb begin
        if (burst_order_interleaved) begin
            cur_low = base_q[BURST_W-1:0] ^ step_q;
        end else begin
            cur_low = base_q[BURST_W-1:0] + step_q;
        end
    end
    assign cur_addr = {base_q[ADDR_W-1:BURST_W], cur_low};

    // output driver state for the cycle after each access edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_q <= 1'b0;
        end else if (asleep) begin
            drive_q <= 1'b0;
        end else if (go) begin
            drive_q <= (op_q == OP_READ);
        end
    end

    // enable acts without the clock; drive_q is low through write data cycles
    assign dq_oe = drive_q && !output_drive_enable_n && !asleep;

    // write pipe: address and lanes wait one edge for the data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr2_valid_q <= 1'b0;
            wr2_addr_q <= ADDR_RST;
            wr2_en_q <= '0;
        end else if (asleep) begin
            wr2_valid_q <= 1'b0;
        end else if (go) begin
            wr2_valid_q <= (op_q == OP_WRITE);
            wr2_addr_q <= cur_addr;
            wr2_en_q <= ~bw_q;
        end
    end

    // an all-lanes-off write is an abort and stores nothing
    assign push_valid = go && !asleep && wr2_valid_q && (|wr2_en_q);
    assign push_entry = '{addr: wr2_addr_q, lane_en: wr2_en_q, data: push_lanes};
    // core writes wait while the edge is ignored or the array sleeps
    assign pop_ready = go && !asleep;
    // forwarding covers only the head entry; stalls gate push and pop alike, so no deeper backlog forms
    assign head_hit = head_valid && (head.addr == cur_addr);

    pbsp_fifo #(
        .WIDTH($bits(pbsp_wr_entry_type)),
        .DEPTH(FIFO_DEPTH)
    ) i_pbsp_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .in_valid(push_valid),
        .in_ready(write_buffer_ready),
        .in_data(push_entry),
        .out_valid(head_valid),
        .out_ready(pop_ready),
        .out_data(head)
    );

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [LANE_W-1:0] lane_mem [MEM_DEPTH];
        logic [LANE_W-1:0] rd_q;

        assign push_lanes[i] = {parity_lines_in[i], dq_in[i*BYTE_W +: BYTE_W]};

        always_ff @(posedge ref_clk) begin
            if (pop_ready && head_valid && head.lane_en[i]) begin
                lane_mem[head.addr] <= head.data[i];
            end
        end

        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                rd_q <= LANE_RST;
            end else if (go && !asleep && op_q == OP_READ) begin
                if (head_hit && head.lane_en[i]) begin
                    rd_q <= head.data[i];
                end else begin
                    rd_q <= lane_mem[cur_addr];
                end
            end
        end

        assign dq_out[i*BYTE_W +: BYTE_W] = rd_q[BYTE_W-1:0];
        assign parity_lines_out[i] = rd_q[BYTE_W];
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_read_cmd;
        load && sel && write_strobe_n;
    endsequence

    sequence s_write_cmd;
        load && sel && !write_strobe_n;
    endsequence

    sequence s_live;
        go && !asleep;
    endsequence

    property p_stall_hold;
        clock_qualify_n && !asleep |=> $stable(op_q) && $stable(step_q) && $stable(base_q) && $stable(drive_q);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("state moved on an ignored edge");

    property p_read_load;
        s_read_cmd |=> op_q == OP_READ && base_q == $past(address);
    endproperty
    a_read_load: assert property (p_read_load) else $error("read command not latched");

    property p_read_drive;
        s_read_cmd ##1 s_live |=> drive_q;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven after next edge");

    property p_oe_gate;
        output_drive_enable_n || asleep |-> !dq_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("outputs driven without enable");

    property p_back_to_back;
        s_read_cmd ##1 s_write_cmd |=> op_q == OP_WRITE;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("command after read not taken");

    property p_deselect;
        (load && !sel) ##1 s_live |=> !dq_oe;
    endproperty
    a_deselect: assert property (p_deselect) else $error("outputs not floated after deselect");

    property p_linear;
        (s_read_cmd and !burst_order_interleaved) ##1 (adv && !burst_order_interleaved)
            |=> cur_low == $past(address[BURST_W-1:0], 2) + BURST_STEP;
    endproperty
    a_linear: assert property (p_linear) else $error("linear burst step wrong");

    property p_interleaved;
        (s_write_cmd and burst_order_interleaved) ##1 (adv && burst_order_interleaved)
            |=> cur_low == ($past(address[BURST_W-1:0], 2) ^ BURST_STEP);
    endproperty
    a_interleaved: assert property (p_interleaved) else $error("interleaved burst step wrong");

    property p_type_kept;
        adv && op_q == OP_WRITE |=> op_q == OP_WRITE;
    endproperty
    a_type_kept: assert property (p_type_kept) else $error("burst changed access type");

    property p_write_float;
        s_write_cmd ##1 go |=> !drive_q && !dq_oe;
    endproperty
    a_write_float: assert property (p_write_float) else $error("outputs driven in write data cycle");

    property p_write_capture;
        s_write_cmd ##1 s_live ##1 (s_live and write_buffer_ready)
            |-> push_valid == ($past(byte_lane_write_n, 2) != LANES_OFF)
                && push_entry.lane_en == ~$past(byte_lane_write_n, 2);
    endproperty
    a_write_capture: assert property (p_write_capture) else $error("write data not taken second edge");

    property p_sleep_entry;
        sleep_request ##1 sleep_request |=> asleep && !dq_oe && op_q == OP_DESELECT;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered in two cycles");

    // exit takes the same two edges as entry, through the same synchroniser
    property p_sleep_exit;
        !sleep_request ##1 !sleep_request |=> !asleep;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left in two cycles");

    property p_step_advance;
        adv && op_q != OP_DESELECT |=> step_q == $past(step_q) + BURST_STEP;
    endproperty
    a_step_advance: assert property (p_step_advance) else $error("burst counter did not advance");
endmodule

// ===== dv/pbsp_ctrl_model.sv
// controller model driving commands and write data into the port
// assumes one calling process, each cmd or stall call owning one clock edge
`timescale 1ns/1ns
module pbsp_ctrl_model (
    input wire logic ref_clk, // clock
    output logic clock_qualify_n, // high stalls the edge
    output logic chip_select_one_n, // select, active low
    output logic chip_select_two, // select, active high
    output logic chip_select_three_n, // select, active low
    output logic advance_or_load, // high advance
    output logic write_strobe_n, // low write
    output logic [pbsp_pkg::LANES-1:0] byte_lane_write_n, // lane selects, active low
    output logic [pbsp_pkg::ADDR_W-1:0] address, // word address
    output logic sleep_request, // sleep, active high
    output logic [pbsp_pkg::DATA_W-1:0] dq_in, // write data
    output logic [pbsp_pkg::LANES-1:0] parity_lines_in // write parity
);
    import pbsp_pkg::*;
    logic [35:0] pipe0 = '0, pipe1 = '0, last = '0;
    logic v0 = 1'h0, v1 = 1'h0, wr_burst = 1'h0;
    initial begin
        {clock_qualify_n, chip_select_one_n, chip_select_two, chip_select_three_n} = 4'h5;
        {advance_or_load, write_strobe_n, sleep_request} = 3'h2;
        byte_lane_write_n = 4'hf;
        address = 18'h0_0000;
        {parity_lines_in, dq_in} = 36'h0_0000_0000;
    end
    // sel bit set means that select is active; wd is only used on write cycles
    task automatic cmd(input logic adv, input logic [2:0] sel, input logic we_n, input logic [3:0] ln,
                       input logic [17:0] a, input logic [35:0] wd);
        logic wr;
        logic [35:0] d;
        wr = adv ? wr_burst : &sel & !we_n;
        wr_burst = wr;
        // data two calls late; idle lines toggle so stale values never match
        d = v1 ? pipe1 : ~last;
        last = d;
        {pipe1, v1} = {pipe0, v0};
        {pipe0, v0} = {wd, wr};
        @(posedge ref_clk);
        clock_qualify_n <= 1'h0;
        chip_select_one_n <= ~sel[0];
        chip_select_two <= sel[1];
        chip_select_three_n <= ~sel[2];
        advance_or_load <= adv;
        write_strobe_n <= we_n;
        byte_lane_write_n <= ln;
        address <= a;
        {parity_lines_in, dq_in} <= d;
    endtask
    task automatic stall();
        @(posedge ref_clk);
        clock_qualify_n <= 1'h1;
    endtask
    task automatic doze(input logic v);
        sleep_request <= v;
    endtask
endmodule

// ===== dv/pbsp_port_tb.sv
// testbench for the pipelined burst sram port, judged against a word model
// assumes the controller model owns every command pin
`timescale 1ns/1ns
module pbsp_port_tb;
    import pbsp_pkg::*;
    logic ref_clk = 1'h0;
    logic resetn, burst_order_interleaved, output_drive_enable_n;
    logic clock_qualify_n, chip_select_one_n, chip_select_two, chip_select_three_n;
    logic advance_or_load, write_strobe_n, sleep_request, dq_oe, write_buffer_ready;
    logic [3:0] byte_lane_write_n, parity_lines_in, parity_lines_out;
    logic [17:0] address;
    logic [31:0] dq_in, dq_out;
    logic [35:0] mem [logic [17:0]];
    int fail_count = 0;
    int comparisons = 0;
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    pbsp_ctrl_model i_pbsp_ctrl_model (.ref_clk(ref_clk), .clock_qualify_n(clock_qualify_n),
        .chip_select_one_n(chip_select_one_n), .chip_select_two(chip_select_two),
        .chip_select_three_n(chip_select_three_n), .advance_or_load(advance_or_load),
        .write_strobe_n(write_strobe_n), .byte_lane_write_n(byte_lane_write_n), .address(address),
        .sleep_request(sleep_request), .dq_in(dq_in), .parity_lines_in(parity_lines_in));
    pbsp_port i_pbsp_port (.ref_clk(ref_clk), .resetn(resetn), .clock_qualify_n(clock_qualify_n),
        .chip_select_one_n(chip_select_one_n), .chip_select_two(chip_select_two),
        .chip_select_three_n(chip_select_three_n), .advance_or_load(advance_or_load),
        .write_strobe_n(write_strobe_n), .byte_lane_write_n(byte_lane_write_n), .address(address),
        .burst_order_interleaved(burst_order_interleaved), .output_drive_enable_n(output_drive_enable_n),
        .sleep_request(sleep_request), .dq_in(dq_in), .parity_lines_in(parity_lines_in), .dq_out(dq_out),
        .parity_lines_out(parity_lines_out), .dq_oe(dq_oe), .write_buffer_ready(write_buffer_ready));
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // lane i is dq byte i plus parity bit i
    function automatic logic [35:0] lmask(input logic [3:0] ln);
        lmask = '0;
        for (int i = 0; i < 4; i++) begin
            lmask[32+i] = !ln[i];
            lmask[8*i+:8] = {8{!ln[i]}};
        end
    endfunction
    function automatic logic [17:0] baddr(input logic [17:0] b, input logic [1:0] k);
        baddr = b;
        baddr[1:0] = burst_order_interleaved ? b[1:0] ^ k : b[1:0] + k;
    endfunction
    task automatic idle();
        i_pbsp_ctrl_model.cmd(1'h0, 3'h0, 1'h1, 4'hf, 18'h0_0000, 36'h0_0000_0000);
    endtask
    task automatic rd(input logic [17:0] a);
        i_pbsp_ctrl_model.cmd(1'h0, 3'h7, 1'h1, 4'hf, a, 36'h0_0000_0000);
    endtask
    task automatic wr(input logic [17:0] a, input logic [3:0] ln, input logic [35:0] d);
        i_pbsp_ctrl_model.cmd(1'h0, 3'h7, 1'h0, ln, a, d);
        mem[a] = (mem[a] & ~lmask(ln)) | (d & lmask(ln));
    endtask
    // selects inactive and strobe low on purpose: both must be ignored
    task automatic adv(input logic [3:0] ln, input logic [35:0] d, input logic [17:0] ea);
        i_pbsp_ctrl_model.cmd(1'h1, 3'h0, 1'h0, ln, 18'h3_ffff, d);
        mem[ea] = (mem[ea] & ~lmask(ln)) | (d & lmask(ln));
    endtask
    task automatic rdchk(input logic [17:0] a);
        repeat (3) idle();
        rd(a);
        repeat (2) idle();
        #1;
        chk({parity_lines_out, dq_out}, mem[a]);
        chk(dq_oe, 1'h1);
    endtask
    task automatic s_basic();
        #1;
        chk(dq_oe, 1'h0);
        chk(write_buffer_ready, 1'h1);
        wr(18'h0_0100, 4'h0, 36'h1_2345_6789);
        wr(18'h0_0101, 4'h0, 36'h9_8765_4321);
        repeat (2) idle();
        rd(18'h0_0100);
        wr(18'h0_0102, 4'h0, 36'h5_5555_aaaa);
        rd(18'h0_0101);
        #1;
        chk({parity_lines_out, dq_out}, mem[18'h0_0100]);
        idle();
        #1;
        chk(dq_oe, 1'h0);
        idle();
        #1;
        chk({parity_lines_out, dq_out}, mem[18'h0_0101]);
        chk(dq_oe, 1'h1);
        idle();
        #1;
        chk(dq_oe, 1'h0);
        rdchk(18'h0_0102);
        for (int i = 0; i < 4; i++) begin
            wr(18'h0_0102, 4'hf ^ (4'h1 << i), 36'h3_c3c3_c3c3 ^ {9{4'(i)}});
            rdchk(18'h0_0102);
        end
        wr(18'h0_0102, 4'hf, 36'h0_0000_0000);
        rdchk(18'h0_0102);
    endtask
    task automatic s_desel();
        for (int i = 0; i < 3; i++) begin
            rd(18'h0_0100);
            i_pbsp_ctrl_model.cmd(1'h0, 3'h7 ^ (3'h1 << i), 1'h1, 4'hf, 18'h0_0101, '0);
            idle();
            #1;
            chk(dq_oe, 1'h1);
            idle();
            #1;
            chk(dq_oe, 1'h0);
        end
    endtask
    task automatic s_stall();
        rdchk(18'h0_0101);
        rd(18'h0_0100);
        i_pbsp_ctrl_model.stall();
        i_pbsp_ctrl_model.stall();
        idle();
        #1;
        chk({parity_lines_out, dq_out}, mem[18'h0_0101]);
        idle();
        #1;
        chk({parity_lines_out, dq_out}, mem[18'h0_0100]);
    endtask
    task automatic s_oe();
        rd(18'h0_0100);
        repeat (2) adv(4'hf, '0, 18'h0_0100);
        #1;
        chk(dq_oe, 1'h1);
        adv(4'hf, '0, 18'h0_0100);
        output_drive_enable_n <= 1'h1;
        #1;
        chk(dq_oe, 1'h0);
        idle();
        output_drive_enable_n <= 1'h0;
        #1;
        chk(dq_oe, 1'h1);
    endtask
    task automatic s_burst(input logic mode, input logic [17:0] s);
        @(posedge ref_clk);
        burst_order_interleaved <= mode;
        wr(s, 4'h0, {4'ha, 23'h00_0000, mode, 8'h50});
        // fifth step wraps onto the start word, lane 0 only
        for (int k = 1; k < 5; k++) begin
            adv(k == 4 ? 4'he : 4'h0, {4'ha, 23'h00_0000, mode, 4'h5, 4'(k)}, baddr(s, 2'(k)));
        end
        repeat (3) idle();
        rd(s);
        for (int k = 0; k < 5; k++) begin
            if (k < 3)
                adv(4'hf, '0, s);
            else
                idle();
            if (k > 0) begin
                #1;
                chk({parity_lines_out, dq_out}, mem[baddr(s, 2'(k - 1))]);
            end
        end
    endtask
    task automatic s_sleep();
        rd(18'h0_0100);
        idle();
        i_pbsp_ctrl_model.stall();
        i_pbsp_ctrl_model.doze(1'h1);
        i_pbsp_ctrl_model.stall();
        #1;
        chk(dq_oe, 1'h1);
        i_pbsp_ctrl_model.stall();
        #1;
        chk(dq_oe, 1'h0);
        i_pbsp_ctrl_model.doze(1'h0);
        repeat (3) idle();
        rdchk(18'h0_0100);
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // the full sequence needs well under a thousand cycles
    initial begin
        #(CLK_PERIOD_NS * 5000);
        fail_count++;
        end_sim();
    end
    initial begin
        resetn = 1'h0;
        burst_order_interleaved = 1'h0;
        output_drive_enable_n = 1'h0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'h1;
        s_basic();
        s_desel();
        s_stall();
        s_oe();
        s_burst(1'h0, 18'h0_0301);
        s_burst(1'h1, 18'h0_0402);
        s_sleep();
        end_sim();
    end
endmodule
